// >>> rtl/cssel_top.v
// Function
// - LF crystal wake start-up is 1K cycles, or 32K with select bit set
// - LF crystal reset delay: 14 cycles, plus 4.1 ms or 65 ms; 11 reserved
// - Clock source code 0010 selects the internal RC oscillator, no components
// - RC oscillator: 6 cycle wake start-up; reset delay per start-up field
// - Every chip reset loads factory calibration byte into trim register
// - Trim register is 8-bit read/write; writes act on oscillator at once
// - Top trim bit picks low or high overlapping frequency range
// - Low seven trim bits tune frequency monotonically within the range
// - Watchdog and reset time-out stay on the watchdog oscillator
// - Clock source code 0011 selects the 128 kHz internal oscillator
// - 128 kHz source: 6 cycle wake; reset delay 14, +4 ms or +64 ms
// - External clock: 6 cycle wake; reset delay 14, +4.1 ms or +65 ms
// - Shipped default is RC oscillator with slowly rising power option
// - Divide-by-eight fuse divides internal clock by eight when programmed
`include "cssel_defines.vh"
`timescale 1ns/10ps
`default_nettype none

module cssel_top (
  // APB slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Fuse and calibration pins
  input wire [3:0] clock_source_select_field,
  input wire [1:0] startup_time_field,
  input wire divide_by_eight_fuse,
  input wire [7:0] factory_calibration,
  // Oscillator outputs seen as pins: lf, rc, 128k, external, watchdog
  input wire [4:0] osc_clk_in,
  // Clock control outputs
  output reg [3:0] source_enable,
  output reg [7:0] rc_oscillator_trim,
  output reg divide_by_eight,
  output reg clock_run,
  output reg internal_reset_n
);

  // ****************************************************************
  // States
  // ****************************************************************
  localparam ST_LOAD = 8'h01;
  localparam ST_START = 8'h02;
  localparam ST_BASE = 8'h04;
  localparam ST_MS = 8'h08;
  localparam ST_RUN = 8'h10;
  localparam ST_SLEEP = 8'h20;
  localparam ST_WAKE = 8'h40;
  localparam ST_HALT = 8'h80;

  reg [7:0] state;
  reg [7:0] next_state;
  reg [15:0] count;
  reg [15:0] next_count;
  reg [3:0] fuse_src;
  reg [1:0] fuse_sut;
  reg fuse_div8;
  reg [3:0] src_s1;
  reg [3:0] src_s2;
  reg [1:0] sut_s1;
  reg [1:0] sut_s2;
  reg div8_s1;
  reg div8_s2;
  reg [7:0] cal_s1;
  reg [7:0] cal_s2;
  reg [4:0] osc_s1;
  reg [4:0] osc_s2;
  reg [4:0] osc_s3;
  reg sleep_req;
  reg rerun_req;
  wire [4:0] osc_edge;
  wire src_tick;
  wire wdt_tick;
  wire apb_write;
  wire apb_setup;
  reg [15:0] start_cycles;
  reg [15:0] ms_cycles;
  reg [3:0] next_enable;
  reg src_valid;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************

  // Two flops per oscillator input, third flop feeds the edge detector
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_osc
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          osc_s1[gi] <= 1'b0;
          osc_s2[gi] <= 1'b0;
          osc_s3[gi] <= 1'b0;
        end else begin
          osc_s1[gi] <= osc_clk_in[gi];
          osc_s2[gi] <= osc_s1[gi];
          osc_s3[gi] <= osc_s2[gi];
        end
      end
      assign osc_edge[gi] = osc_s2[gi] & ~osc_s3[gi];
    end
  endgenerate

  // Fuse and calibration pins pass two flops; no reset, so they track pins during reset
  always @(posedge pclk) begin
    src_s1 <= clock_source_select_field;
    src_s2 <= src_s1;
    sut_s1 <= startup_time_field;
    sut_s2 <= sut_s1;
    div8_s1 <= divide_by_eight_fuse;
    div8_s2 <= div8_s1;
    cal_s1 <= factory_calibration;
    cal_s2 <= cal_s1;
  end

  // ****************************************************************
  // Source decode and counts
  // ****************************************************************

  // Selected source enable and wake start-up count
  always @* begin
    next_enable = 4'h0;
    src_valid = 1'b1;
    start_cycles = `CSSEL_START_FAST;
    if (fuse_src[3:1] == `CSSEL_SRC_LFXTAL_HI) begin
      next_enable = 4'h1;
      start_cycles = fuse_src[0] ? `CSSEL_START_LF1 : `CSSEL_START_LF0;
    end else if (fuse_src == `CSSEL_SRC_RC) begin
      next_enable = 4'h2;
    end else if (fuse_src == `CSSEL_SRC_LP128) begin
      next_enable = 4'h4;
    end else if (fuse_src == `CSSEL_SRC_EXT) begin
      next_enable = 4'h8;
    end else begin
      src_valid = 1'b0;
    end
  end

  // Extra reset delay in watchdog cycles, same for every source
  always @* begin
    case (fuse_sut)
      `CSSEL_SUT_SHORT: ms_cycles = `CSSEL_WDT_SHORT;
      `CSSEL_SUT_LONG: ms_cycles = `CSSEL_WDT_LONG;
      default: ms_cycles = 16'h0000;
    endcase
  end

  // Cycle of the selected source; ms delay ticks on the watchdog clock
  assign src_tick = |(osc_edge[3:0] & source_enable);
  assign wdt_tick = osc_edge[4];

  // ****************************************************************
  // Start-up sequencer
  // ****************************************************************

  // Next state and counter
  always @* begin
    next_state = state;
    next_count = count;
    case (state)
      ST_LOAD: begin
        next_count = 16'h0000;
        next_state = ST_START; // Fuses land at this edge, decoded in START
      end
      ST_START: begin
        if (!src_valid || fuse_sut == `CSSEL_SUT_RSVD) begin
          next_state = ST_HALT;
        end else if (count >= start_cycles) begin
          next_state = ST_BASE;
          next_count = 16'h0000;
        end else if (src_tick) begin
          next_count = count + 16'h0001;
        end
      end
      ST_BASE: begin
        if (count >= `CSSEL_DELAY_BASE) begin
          next_state = ST_MS;
          next_count = 16'h0000;
        end else if (src_tick) begin
          next_count = count + 16'h0001;
        end
      end
      ST_MS: begin
        if (count >= ms_cycles) begin
          next_state = ST_RUN;
          next_count = 16'h0000;
        end else if (wdt_tick) begin
          next_count = count + 16'h0001;
        end
      end
      ST_RUN: begin
        if (sleep_req) begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        next_count = 16'h0000;
        if (!sleep_req) begin
          next_state = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (count >= start_cycles) begin
          next_state = ST_RUN;
          next_count = 16'h0000;
        end else if (src_tick) begin
          next_count = count + 16'h0001;
        end
      end
      ST_HALT: begin
        next_count = 16'h0000;
      end
      default: begin
        next_state = ST_LOAD;
        next_count = 16'h0000;
      end
    endcase
    if (rerun_req) begin
      next_state = ST_LOAD;
      next_count = 16'h0000;
    end
  end

  // State, counter and fuse capture at the start of each reset sequence
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_LOAD;
      count <= 16'h0000;
      fuse_src <= `CSSEL_DEF_SRC;
      fuse_sut <= `CSSEL_DEF_SUT;
      fuse_div8 <= `CSSEL_DEF_DIV8;
    end else begin
      state <= next_state;
      count <= next_count;
      if (state == ST_LOAD) begin
        fuse_src <= src_s2;
        fuse_sut <= sut_s2;
        fuse_div8 <= div8_s2;
      end
    end
  end

  // Registered clock control outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      source_enable <= 4'h0;
      divide_by_eight <= `CSSEL_DEF_DIV8;
      clock_run <= 1'b0;
      internal_reset_n <= 1'b0;
    end else begin
      source_enable <= (state == ST_HALT || state == ST_LOAD || next_state == ST_HALT) ?
                       4'h0 : next_enable;
      divide_by_eight <= fuse_div8;
      clock_run <= (next_state == ST_RUN);
      internal_reset_n <= (next_state == ST_RUN) || (next_state == ST_SLEEP) ||
                          (next_state == ST_WAKE);
    end
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & pready & pwrite;

  // Trim and control registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_oscillator_trim <= `CSSEL_DEF_TRIM;
      sleep_req <= 1'b0;
      rerun_req <= 1'b0;
    end else begin
      rerun_req <= 1'b0;
      if (state == ST_LOAD) begin
        rc_oscillator_trim <= cal_s2;
        sleep_req <= 1'b0;
      end else if (apb_write && paddr == `CSSEL_ADDR_TRIM) begin
        rc_oscillator_trim <= pwdata[7:0];
      end else if (apb_write && paddr == `CSSEL_ADDR_CTRL) begin
        sleep_req <= pwdata[`CSSEL_CTRL_SLEEP];
        rerun_req <= pwdata[`CSSEL_CTRL_RERUN];
      end
    end
  end

  // Zero-wait answer registered in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= apb_setup;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (apb_setup) begin
        case (paddr)
          `CSSEL_ADDR_TRIM: prdata <= {24'h000000, rc_oscillator_trim};
          `CSSEL_ADDR_CTRL: prdata <= {31'h0, sleep_req};
          `CSSEL_ADDR_STATUS: prdata <= {9'h0, fuse_div8, fuse_sut, fuse_src,
                                         count[7:0], state};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule // cssel_top

`default_nettype wire

// >>> include/cssel_defines.vh
`ifndef CSSEL_DEFINES_VH
`define CSSEL_DEFINES_VH

// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define CSSEL_ADDR_TRIM 12'h000
`define CSSEL_ADDR_CTRL 12'h004
`define CSSEL_ADDR_STATUS 12'h008

// Control register fields
`define CSSEL_CTRL_SLEEP 0
`define CSSEL_CTRL_RERUN 1

// ****************************************************************
// Fuse encodings and shipped defaults
// ****************************************************************
`define CSSEL_SRC_EXT 4'h0
`define CSSEL_SRC_RC 4'h2
`define CSSEL_SRC_LP128 4'h3
`define CSSEL_SRC_LFXTAL_HI 3'h2
`define CSSEL_SUT_NONE 2'h0
`define CSSEL_SUT_SHORT 2'h1
`define CSSEL_SUT_LONG 2'h2
`define CSSEL_SUT_RSVD 2'h3
`define CSSEL_DEF_SRC 4'h2
`define CSSEL_DEF_SUT 2'h2
`define CSSEL_DEF_DIV8 1'h1
`define CSSEL_DEF_TRIM 8'h80

// ****************************************************************
// Start-up counts in source clock cycles
// ****************************************************************
`define CSSEL_START_LF0 16'h0400
`define CSSEL_START_LF1 16'h8000
`define CSSEL_START_FAST 16'h0006
`define CSSEL_DELAY_BASE 16'h000e

// Millisecond delays in watchdog oscillator cycles
`define CSSEL_WDT_SHORT 16'h0200
`define CSSEL_WDT_LONG 16'h2000

`endif

// >>> test/cssel_osc_model.sv
`timescale 1ns/10ps
`default_nettype none
// *****
// Oscillator pins model
// *****
module cssel_osc_model #(
  parameter integer SRC_HALF = 3,
  parameter integer WDT_HALF = 4
) (
  // Clock
  input wire logic pclk,
  // Oscillator pins
  output var logic [4:0] osc_clk_in
);
  integer sc = 0;
  integer wc = 0;
  initial osc_clk_in = 5'h00;
  // Steady toggling, never a step in frequency
  always @(posedge pclk) begin
    sc <= (sc + 1) % SRC_HALF;
    wc <= (wc + 1) % WDT_HALF;
    if (sc == SRC_HALF - 1) osc_clk_in[3:0] <= ~osc_clk_in[3:0];
    if (wc == WDT_HALF - 1) osc_clk_in[4] <= ~osc_clk_in[4];
  end
endmodule // cssel_osc_model
`default_nettype wire

// >>> test/cssel_props.sv
`timescale 1ns/10ps
`default_nettype none
// *****
// Port checker
// *****
module cssel_props (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Fuses
  input wire logic [3:0] clock_source_select_field,
  input wire logic [1:0] startup_time_field,
  input wire logic divide_by_eight_fuse,
  input wire logic [7:0] factory_calibration,
  // Clock control
  input wire logic [3:0] source_enable,
  input wire logic [7:0] rc_oscillator_trim,
  input wire logic divide_by_eight,
  input wire logic clock_run,
  input wire logic internal_reset_n
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Transfer steps
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_trim_wr;
    psel && penable && pready && pwrite && paddr == 12'h000 && internal_reset_n;
  endsequence
  // Bus, trim and sequencer relations
  a_ready_one_cycle: assert property (s_setup |=> pready ##1 !pready)
    else $error("pready not one cycle");
  a_trim_read_back: assert property (
    pready && !pwrite && paddr == 12'h000 |-> prdata == {24'h0, rc_oscillator_trim})
    else $error("trim read wrong");
  a_trim_write_now: assert property (
    s_trim_wr |=> {24'h0, rc_oscillator_trim} == ($past(pwdata) & 32'hff))
    else $error("trim write lost");
  a_cal_on_reset: assert property (
    $rose(presetn) |-> ##[1:4] rc_oscillator_trim == factory_calibration)
    else $error("calibration not loaded");
  a_run_after_reset: assert property (clock_run |-> internal_reset_n)
    else $error("run while in reset");
  a_div_fuse_out: assert property (
    internal_reset_n |-> divide_by_eight == divide_by_eight_fuse)
    else $error("divide fuse wrong");
  a_rc_source_pick: assert property (
    internal_reset_n && clock_source_select_field == 4'h2 |-> source_enable == 4'h2)
    else $error("rc not enabled");
  a_lp_source_pick: assert property (
    internal_reset_n && clock_source_select_field == 4'h3 |-> source_enable == 4'h4)
    else $error("128k not enabled");
  a_rsvd_code_halt: assert property (
    startup_time_field == 2'h3 |-> !internal_reset_n && source_enable == 4'h0)
    else $error("reserved code ran");
endmodule // cssel_props
bind cssel_top cssel_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .clock_source_select_field, .startup_time_field,
  .divide_by_eight_fuse, .factory_calibration, .source_enable, .rc_oscillator_trim,
  .divide_by_eight, .clock_run, .internal_reset_n);
`default_nettype wire

// >>> test/clock_source_startup_select_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// *****
// Testbench top
// *****
module clock_source_startup_select_tb_top;
  localparam integer SP = 6;
  localparam integer WP = 8;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, divide_by_eight, clock_run, internal_reset_n;
  logic [3:0] clock_source_select_field = 4'h2, source_enable;
  logic [1:0] startup_time_field = 2'h0;
  logic divide_by_eight_fuse = 1'b1;
  logic [7:0] factory_calibration = 8'h5a, rc_oscillator_trim;
  logic [4:0] osc_clk_in;
  integer failures = 0, compares = 0;
  // Clock
  always #5 pclk = ~pclk;
  // Oscillators and design
  cssel_osc_model #(.SRC_HALF(SP / 2), .WDT_HALF(WP / 2)) u_osc (.pclk, .osc_clk_in);
  cssel_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .clock_source_select_field, .startup_time_field,
    .divide_by_eight_fuse, .factory_calibration, .osc_clk_in, .source_enable,
    .rc_oscillator_trim, .divide_by_eight, .clock_run, .internal_reset_n);
  // Value compare
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // Cycle count compare, oscillator phase allowed for
  task automatic near(input string nm, input integer e, input integer g);
    compares++;
    if (g < e - 32 || g > e + 32) begin
      failures++;
      $display("BAD %s exp %0d got %0d", nm, e, g);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Cycles until the clock runs
  task automatic wait_run(output integer n);
    n = 0;
    while (clock_run !== 1'b1 && n < 12000) begin
      @(posedge pclk);
      n++;
    end
  endtask
  // Chip reset with new fuse values
  task automatic boot(input logic [3:0] s, input logic [1:0] t, input logic d);
    @(posedge pclk);
    presetn <= 1'b0;
    clock_source_select_field <= s;
    startup_time_field <= t;
    divide_by_eight_fuse <= d;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  // Boot one source and time the release
  task automatic t_src(input logic [3:0] s, input logic [1:0] t, input integer e,
    input logic [3:0] en, input logic d);
    integer n;
    boot(s, t, d);
    wait_run(n);
    near("boot cycles", e, n);
    chk("source enable", {28'h0, en}, {28'h0, source_enable});
    chk("divide", {31'h0, d}, {31'h0, divide_by_eight});
    chk("reset out", 32'h1, {31'h0, internal_reset_n});
  endtask
  // Sequence must still be held at a given state
  task automatic t_held(input logic [3:0] s, input logic [1:0] t, input integer c,
    input logic [7:0] st);
    boot(s, t, 1'b1);
    repeat (c) @(posedge pclk);
    apb(1'b0, 12'h008, 32'h0);
    chk("held state", {24'h0, st}, {24'h0, rd[7:0]});
  endtask
  // Sleep, then wake on the start count only
  task automatic t_sleep;
    integer n;
    apb(1'b1, 12'h004, 32'h1);
    repeat (3) @(posedge pclk);
    chk("run in sleep", 32'h0, {31'h0, clock_run});
    apb(1'b1, 12'h004, 32'h0);
    wait_run(n);
    near("wake cycles", 6 * SP, n);
  endtask
  // Trim load, boundary values, unmapped place, reload
  task automatic t_trim;
    logic [7:0] v [4] = '{8'h7f, 8'h80, 8'h00, 8'hff};
    integer n;
    apb(1'b0, 12'h000, 32'h0);
    chk("trim load", 32'h5a, rd);
    foreach (v[i]) begin
      apb(1'b1, 12'h000, {24'hffffff, v[i]});
      apb(1'b0, 12'h000, 32'h0);
      chk("trim read", {24'h0, v[i]}, rd);
      chk("trim pin", {24'h0, v[i]}, {24'h0, rc_oscillator_trim});
    end
    apb(1'b0, 12'hffc, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    apb(1'b1, 12'h004, 32'h2);
    repeat (3) @(posedge pclk); // Let the old run flag drop first
    wait_run(n);
    near("rerun cycles", 20 * SP, n);
    chk("trim reload", 32'h5a, {24'h0, rc_oscillator_trim});
  endtask
  // Verdict and end of run
  task automatic end_sim;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    t_src(4'h0, 2'h0, 20 * SP, 4'h8, 1'b0);
    t_src(4'h2, 2'h1, 20 * SP + 512 * WP, 4'h2, 1'b1);
    t_src(4'h3, 2'h1, 20 * SP + 512 * WP, 4'h4, 1'b1);
    t_src(4'h4, 2'h0, 1038 * SP, 4'h1, 1'b1);
    t_held(4'h5, 2'h0, 1038 * SP + 64, 8'h02);
    t_held(4'h2, 2'h3, 300, 8'h80);
    t_src(4'h2, 2'h0, 20 * SP, 4'h2, 1'b1);
    t_sleep;
    t_trim;
    end_sim;
  end
  // Watchdog against a hang
  initial begin
    repeat (80000) @(posedge pclk);
    failures++;
    end_sim;
  end
endmodule // clock_source_startup_select_tb_top
`default_nettype wire
